// ===== core/cpu_regs.vh
// constants for the processor core register set
`ifndef CPU_REGS_VH
`define CPU_REGS_VH
`define STACK_PTR_RESET 16'h00ff
`define IXH_RESET 8'h00
`define STACK_LOW_RELOAD 8'hff
`define VEC_HI_ADDR 16'hfffe
`define VEC_LO_ADDR 16'hffff
`define DIRECT_PAGE_HI 8'h00
`define OP_NOP 5'h00
`define OP_LDA 5'h01
`define OP_STA 5'h02
`define OP_TAX 5'h03
`define OP_TXA 5'h04
`define OP_CLRX 5'h05
`define OP_INCX 5'h06
`define OP_DECX 5'h07
`define OP_COMX 5'h08
`define OP_NEGX 5'h09
`define OP_LSLX 5'h0a
`define OP_LSRX 5'h0b
`define OP_ROLX 5'h0c
`define OP_RORX 5'h0d
`define OP_LDHX 5'h0e
`define OP_LDX 5'h0f
`define OP_STACK_ADJ 5'h10
`define OP_STACK_LOW_RELOAD 5'h11
`define OP_PUSH 5'h12
`define OP_PULL 5'h13
`define OP_ADD 5'h14
`define OP_SUB 5'h15
`define OP_MUL 5'h16
`define OP_DIV 5'h17
`define OP_BRA 5'h18
`define OP_LDSP 5'h19
`define AM_DIR 3'h0
`define AM_EXT 3'h1
`define AM_IX 3'h2
`define AM_IX1 3'h3
`define AM_IX2 3'h4
`define AM_IXP 3'h5
`define AM_IX1P 3'h6
`define AM_SP1 3'h7
`define CC_V 4
`define CC_HALF 3
`define CC_N 2
`define CC_Z 1
`define CC_C 0
`endif

// ===== core/reg8_noreset.v
// 8-bit register with load enable and no reset value
`timescale 1ns/1ps
module reg8_noreset (
  input wire sys_clk,
  input wire load,
  input wire [7:0] d,
  output reg [7:0] q
);
  always @(posedge sys_clk) begin
    if (load) begin
      q <= d;
    end
  end
endmodule // reg8_noreset

// ===== core/cpu_core_register_set.v
// programmer-visible register set of the 8-bit processor core
`timescale 1ns/1ps
`include "cpu_regs.vh"
module cpu_core_register_set (
  input wire sys_clk,
  input wire rst,
  input wire op_valid,
  input wire [4:0] op_code,
  input wire [2:0] addr_mode,
  input wire [15:0] operand,
  input wire [7:0] mem_rdata,
  input wire [15:0] branch_base,
  input wire [15:0] vector_word,
  output reg [15:0] mem_addr,
  output reg [7:0] mem_wdata,
  output reg mem_we,
  output reg [7:0] result_holder_out,
  output reg [15:0] index_pair_out,
  output reg [15:0] stack_pointer_out,
  output reg [15:0] instruction_pointer,
  output reg [4:0] cond_codes,
  output reg div_error
);
  wire [7:0] result_holder;
  wire [7:0] index_lower_byte;
  reg [7:0] index_upper_byte;
  reg [15:0] stack_pointer;
  reg [7:0] next_a;
  reg load_a;
  reg [7:0] next_x;
  reg load_x;
  reg [15:0] ea;
  reg [15:0] index_pair;
  reg [8:0] sum9;
  reg [4:0] half;
  reg [15:0] prod;
  reg [15:0] dividend;
  reg [15:0] quot;
  reg [15:0] rem;
  reg [4:0] next_cc;
  reg first;

  // a no-reset, flops: keep on reset
  // no reset value
  reg8_noreset acc_reg (
    .sys_clk(sys_clk),
    .load(load_a),
    .d(next_a),
    .q(result_holder)
  );
  reg8_noreset ixl_reg (
    .sys_clk(sys_clk),
    .load(load_x),
    .d(next_x),
    .q(index_lower_byte)
  );

  // effective address decode
  always @* begin
    index_pair = {index_upper_byte, index_lower_byte};
    ea = 16'h0000;
    case (addr_mode)
      `AM_DIR: ea = {`DIRECT_PAGE_HI, operand[7:0]};
      `AM_EXT: ea = operand;
      `AM_IX, `AM_IXP: ea = index_pair;
      `AM_IX1, `AM_IX1P: ea = index_pair + {8'h00, operand[7:0]};
      `AM_IX2: ea = index_pair + operand;
      `AM_SP1: ea = stack_pointer + {8'h00, operand[7:0]};
      default: ea = 16'h0000;
    endcase
  end

  // data path for the two 8-bit registers
  always @* begin
    next_a = result_holder;
    load_a = 1'b0;
    next_x = index_lower_byte;
    load_x = 1'b0;
    next_cc = cond_codes;
    sum9 = 9'h000;
    half = 5'h00;
    prod = 16'h0000;
    dividend = {index_upper_byte, result_holder};
    quot = 16'h0000;
    rem = 16'h0000;
    if (op_valid && !first) begin
      case (op_code)
        `OP_LDA: begin
          next_a = mem_rdata;
          load_a = 1'b1;
        end
        `OP_LDX: begin
          next_x = operand[7:0];
          load_x = 1'b1;
        end
        `OP_TAX: begin
          next_x = result_holder;
          load_x = 1'b1;
        end
        `OP_TXA: begin
          next_a = index_lower_byte;
          load_a = 1'b1;
        end
        `OP_CLRX: begin
          next_x = 8'h00;
          load_x = 1'b1;
        end
        `OP_INCX: begin
          next_x = index_lower_byte + 8'h01;
          load_x = 1'b1;
        end
        `OP_DECX: begin
          next_x = index_lower_byte - 8'h01;
          load_x = 1'b1;
        end
        `OP_COMX: begin
          next_x = ~index_lower_byte;
          load_x = 1'b1;
        end
        `OP_NEGX: begin
          next_x = 8'h00 - index_lower_byte;
          load_x = 1'b1;
        end
        `OP_LSLX: begin
          next_x = {index_lower_byte[6:0], 1'b0};
          next_cc[`CC_C] = index_lower_byte[7];
          load_x = 1'b1;
        end
        `OP_LSRX: begin
          next_x = {1'b0, index_lower_byte[7:1]};
          next_cc[`CC_C] = index_lower_byte[0];
          load_x = 1'b1;
        end
        `OP_ROLX: begin
          next_x = {index_lower_byte[6:0], cond_codes[`CC_C]};
          next_cc[`CC_C] = index_lower_byte[7];
          load_x = 1'b1;
        end
        `OP_RORX: begin
          next_x = {cond_codes[`CC_C], index_lower_byte[7:1]};
          next_cc[`CC_C] = index_lower_byte[0];
          load_x = 1'b1;
        end
        `OP_LDHX: begin
          next_x = operand[7:0];
          load_x = 1'b1;
        end
        `OP_ADD: begin
          sum9 = {1'b0, result_holder} + {1'b0, mem_rdata};
          half = {1'b0, result_holder[3:0]} + {1'b0, mem_rdata[3:0]};
          next_a = sum9[7:0];
          load_a = 1'b1;
          next_cc[`CC_C] = sum9[8];
          next_cc[`CC_HALF] = half[4];
          next_cc[`CC_V] = (result_holder[7] == mem_rdata[7]) && (sum9[7] != result_holder[7]);
        end
        `OP_SUB: begin
          sum9 = {1'b0, result_holder} - {1'b0, mem_rdata};
          next_a = sum9[7:0];
          load_a = 1'b1;
          next_cc[`CC_C] = sum9[8];
          next_cc[`CC_V] = (result_holder[7] != mem_rdata[7]) && (sum9[7] != result_holder[7]);
        end
        `OP_MUL: begin
          prod = result_holder * index_lower_byte;
          next_a = prod[7:0];
          next_x = prod[15:8];
          load_a = 1'b1;
          load_x = 1'b1;
          next_cc[`CC_C] = 1'b0;
          next_cc[`CC_HALF] = 1'b0;
        end
        `OP_DIV: begin
          if (index_lower_byte != 8'h00) begin
            quot = dividend / {8'h00, index_lower_byte};
            rem = dividend % {8'h00, index_lower_byte};
          end
          // quotient overflow or zero divisor leaves result untouched
          if (index_lower_byte != 8'h00 && quot[15:8] == 8'h00) begin
            next_a = quot[7:0];
            load_a = 1'b1;
            next_cc[`CC_C] = 1'b0;
          end else begin
            next_cc[`CC_C] = 1'b1;
          end
        end
        default: begin
          load_a = 1'b0;
        end
      endcase
      if (load_a) begin
        next_cc[`CC_Z] = (next_a == 8'h00);
        next_cc[`CC_N] = next_a[7];
      end else if (load_x) begin
        next_cc[`CC_Z] = (next_x == 8'h00);
        next_cc[`CC_N] = next_x[7];
      end
    end
  end

  // pointers, memory port and status, all from flops
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      index_upper_byte <= `IXH_RESET;
      stack_pointer <= `STACK_PTR_RESET;
      instruction_pointer <= 16'h0000;
      first <= 1'b1;
      mem_addr <= 16'h0000;
      mem_wdata <= 8'h00;
      mem_we <= 1'b0;
      cond_codes <= 5'h00;
      div_error <= 1'b0;
      result_holder_out <= 8'h00;
      index_pair_out <= 16'h0000;
      stack_pointer_out <= `STACK_PTR_RESET;
    end else begin
      mem_we <= 1'b0;
      cond_codes <= next_cc;
      result_holder_out <= next_a;
      index_pair_out <= {index_upper_byte, next_x};
      stack_pointer_out <= stack_pointer;
      if (first) begin
        instruction_pointer <= vector_word;
        first <= 1'b0;
      end else if (op_valid) begin
        mem_addr <= ea;
        div_error <= (op_code == `OP_DIV) && next_cc[`CC_C];
        case (op_code)
          `OP_STA: begin
            mem_wdata <= result_holder;
            mem_we <= 1'b1;
          end
          // upper byte changes here too, so the pair output must follow it
          `OP_LDHX: begin
            index_upper_byte <= operand[15:8];
            index_pair_out <= operand;
          end
          `OP_DIV: begin
            if (next_cc[`CC_C] == 1'b0) begin
              index_upper_byte <= rem[7:0];
              index_pair_out <= {rem[7:0], next_x};
            end
          end
          `OP_STACK_ADJ: stack_pointer <= stack_pointer + {{8{operand[7]}}, operand[7:0]};
          `OP_STACK_LOW_RELOAD: stack_pointer <= {stack_pointer[15:8], `STACK_LOW_RELOAD};
          `OP_LDSP: stack_pointer <= operand;
          // operand low byte pushed here at the stack pointer, which then decrements
          `OP_PUSH: begin
            mem_addr <= stack_pointer;
            mem_wdata <= operand[7:0];
            mem_we <= 1'b1;
            stack_pointer <= stack_pointer - 16'h0001;
          end
          `OP_PULL: begin
            mem_addr <= stack_pointer + 16'h0001;
            stack_pointer <= stack_pointer + 16'h0001;
          end
          `OP_BRA: instruction_pointer <= branch_base + {{8{operand[7]}}, operand[7:0]};
          default: mem_we <= 1'b0;
        endcase
      end
    end
  end
endmodule // cpu_core_register_set

// ===== tb/cpu_core_register_set_properties.sv
// checker for the core register set ports
`timescale 1ns/1ps
`include "cpu_regs.vh"
module regset_chk (
  input wire sys_clk,
  input wire rst,
  input wire op_valid,
  input wire [4:0] op_code,
  input wire [2:0] addr_mode,
  input wire [15:0] operand,
  input wire [15:0] vector_word,
  input wire [15:0] mem_addr,
  input wire [7:0] mem_wdata,
  input wire mem_we,
  input wire [7:0] result_holder_out,
  input wire [15:0] index_pair_out,
  input wire [15:0] stack_pointer_out,
  input wire [15:0] instruction_pointer
);
  // idle cycles decode as no operation
  wire [4:0] oc = op_valid ? op_code : `OP_NOP;
  wire [15:0] stk = stack_pointer_out;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_reset_values: assert property (disable iff (1'b0) rst |-> stk == `STACK_PTR_RESET &&
    index_pair_out[15:8] == `IXH_RESET) else $error("reset values wrong");
  a_vector_load: assert property ($fell(rst) |=>
    instruction_pointer == $past(vector_word)) else $error("vector not loaded");
  a_push_write: assert property (oc == `OP_PUSH |=> mem_we &&
    mem_addr == $past(stk) && mem_wdata == $past(operand[7:0])) else $error("push write");
  a_push_dec: assert property (oc == `OP_PUSH ##1 !op_valid |=>
    stk == $past(stk, 2) - 16'h0001) else $error("push pointer");
  a_stack_adjust: assert property (oc == `OP_STACK_ADJ ##1 !op_valid |=> stk ==
    $past(stk, 2) + {{8{$past(operand[7], 2)}}, $past(operand[7:0], 2)}) else $error("adjust");
  a_tax_copy: assert property (oc == `OP_TAX |=> index_pair_out ==
    {$past(index_pair_out[15:8]), $past(result_holder_out)}) else $error("transfer");
  a_direct_page: assert property (oc == `OP_LDA && addr_mode == `AM_DIR |=>
    mem_addr == {`DIRECT_PAGE_HI, $past(operand[7:0])}) else $error("direct address");
  a_store_data: assert property (oc == `OP_STA |=> mem_we &&
    mem_wdata == $past(result_holder_out)) else $error("store data");
endmodule // regset_chk

// ===== tb/cpu_core_register_set_tb.sv
// self-checking bench for the core register set
`timescale 1ns/1ps
`include "cpu_regs.vh"
module cpu_core_register_set_tb;
  // reset starts low so that its first rise really triggers the async reset
  reg sys_clk = 1'b0, rst = 1'b0, op_valid = 1'b0;
  reg [4:0] op_code = 5'h0;
  reg [2:0] addr_mode = 3'h0;
  reg [7:0] mem_rdata = 8'h0;
  reg [15:0] operand = 16'h0, branch_base = 16'h0, vector_word = 16'h0;
  wire [15:0] mem_addr, index_pair_out, stack_pointer_out, instruction_pointer;
  wire [7:0] mem_wdata, result_holder_out;
  wire [4:0] cond_codes;
  wire mem_we, div_error;
  integer mismatches = 0, n_compared = 0;
  cpu_core_register_set dut (.sys_clk, .rst, .op_valid, .op_code, .addr_mode, .operand,
    .mem_rdata, .branch_base, .vector_word, .mem_addr, .mem_wdata, .mem_we,
    .result_holder_out, .index_pair_out, .stack_pointer_out, .instruction_pointer,
    .cond_codes, .div_error);
  always #20 sys_clk = ~sys_clk;
  task check(input [15:0] got, input [15:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // memory data rides on the operand low byte to keep calls short
  task op(input [4:0] c, input [2:0] m, input [15:0] v);
    begin
      op_valid = 1'b1;
      op_code = c;
      addr_mode = m;
      operand = v;
      mem_rdata = v[7:0];
      @(posedge sys_clk) #1;
    end
  endtask
  task inh(input [4:0] c);
    op(c, 3'h0, 16'h0);
  endtask
  // stack results lag a cycle, so stack ops are followed by an idle cycle
  task idle;
    begin
      op_valid = 1'b0;
      @(posedge sys_clk) #1;
    end
  endtask
  task xstep(input [4:0] c, input [7:0] e);
    begin
      inh(c);
      check(index_pair_out, {8'h0, e});
    end
  endtask
  task rst_seq(input [15:0] vw);
    begin
      vector_word = vw;
      rst = 1'b1;
      repeat (8) @(posedge sys_clk);
      #1 rst = 1'b0;
      @(posedge sys_clk) #1;
      check(instruction_pointer, vw);
    end
  endtask
  task t_data;
    begin
      op(`OP_LDA, `AM_EXT, 16'h805a);
      check(mem_addr, 16'h805a);
      check(result_holder_out, 16'h5a);
      xstep(`OP_TAX, 8'h5a);
      op(`OP_LDA, `AM_IX, 16'h0011);
      check(mem_addr, 16'h005a);
      inh(`OP_TXA);
      check(result_holder_out, 16'h5a);
      op(`OP_STA, `AM_DIR, 16'h1234);
      op(`OP_LDA, `AM_DIR, 16'h0081);
      xstep(`OP_TAX, 8'h81);
      xstep(`OP_LSLX, 8'h02);
      xstep(`OP_ROLX, 8'h05);
      xstep(`OP_RORX, 8'h02);
      xstep(`OP_LSRX, 8'h01);
      xstep(`OP_COMX, 8'hfe);
      xstep(`OP_NEGX, 8'h02);
      xstep(`OP_INCX, 8'h03);
      xstep(`OP_DECX, 8'h02);
      xstep(`OP_CLRX, 8'h00);
      check(cond_codes[`CC_Z], 16'h1);
    end
  endtask
  task t_stack;
    begin
      op(`OP_PUSH, 3'h0, 16'h00a7);
      check(mem_addr, `STACK_PTR_RESET);
      check(mem_wdata, 16'h00a7);
      idle;
      check(stack_pointer_out, 16'h00fe);
      op(`OP_STACK_ADJ, 3'h0, 16'h007f);
      idle;
      check(stack_pointer_out, 16'h017d);
      inh(`OP_STACK_LOW_RELOAD);
      idle;
      check(stack_pointer_out, 16'h01ff);
      op(`OP_STACK_ADJ, 3'h0, 16'h0080);
      idle;
      check(stack_pointer_out, 16'h017f);
    end
  endtask
  task t_arith;
    begin
      inh(`OP_DIV);
      check(div_error, 16'h1);
      op(`OP_LDA, `AM_DIR, 16'h0012);
      xstep(`OP_TAX, 8'h12);
      op(`OP_LDA, `AM_DIR, 16'h0034);
      inh(`OP_MUL);
      check({index_pair_out[7:0], result_holder_out}, 16'h03a8);
      check(cond_codes[`CC_N], 16'h1);
      branch_base = 16'h1000;
      op(`OP_BRA, 3'h0, 16'h00f0);
      check(instruction_pointer, 16'h0ff0);
    end
  endtask
  task t_keep;
    begin
      idle;
      rst_seq(16'h4321);
      check(result_holder_out, 16'h00a8);
      check(index_pair_out, 16'h0003);
    end
  endtask
  // pair load, offset index, add, subtract, pull
  task t_more;
    begin
      op(`OP_LDHX, 3'h0, 16'h1234);
      check(index_pair_out, 16'h1234);
      op(`OP_LDA, `AM_IX1P, 16'h0010);
      check(mem_addr, 16'h1244);
      op(`OP_ADD, 3'h0, 16'h0090);
      check(result_holder_out, 16'h00a0);
      op(`OP_SUB, 3'h0, 16'h00b0);
      check(result_holder_out, 16'h00f0);
      check(cond_codes[`CC_C], 16'h1);
      op(`OP_PULL, 3'h0, 16'h0000);
      check(mem_addr, 16'h0100);
      idle;
      check(stack_pointer_out, 16'h0100);
      op(`OP_LDSP, 3'h0, 16'h0200);
      idle;
      check(stack_pointer_out, 16'h0200);
    end
  endtask
  task test_done;
    begin
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  initial begin
    #1;
    rst_seq(16'hc0de);
    t_data;
    t_stack;
    t_arith;
    t_keep;
    t_more;
    test_done;
  end
  // the whole run needs about 2.3 us
  initial begin
    #100000;
    mismatches = mismatches + 1;
    test_done;
  end
endmodule // cpu_core_register_set_tb
bind cpu_core_register_set regset_chk chk (.sys_clk, .rst, .op_valid, .op_code, .addr_mode,
  .operand, .vector_word, .mem_addr, .mem_wdata, .mem_we, .result_holder_out,
  .index_pair_out, .stack_pointer_out, .instruction_pointer);
